//--- hw/status_irq_pkg.sv
// status and interrupt block constants and types
package status_irq_pkg;

    // ----------------------------------------
    // apb register map
    // ----------------------------------------
    localparam logic [7:0] LIVE_OFS = 8'h00;
    localparam logic [7:0] STICKY_OFS = 8'h04;
    localparam logic [7:0] IRQ_EN_OFS = 8'h08;
    localparam logic [7:0] MODE_OFS = 8'h0C;
    localparam int ADDR_W = 8;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int COND_N = 6;
    localparam int LIVE_N = 8;
    localparam int INPUT0_BIT = 0;
    localparam int INPUT1_BIT = 1;
    localparam int JPLL_BIT = 2;
    localparam int SPLL_BIT = 3;
    localparam int HOLD_BIT = 4;
    localparam int REF_BIT = 5;
    localparam int VCO_BIT = 6;
    localparam int SEL_BIT = 7;
    localparam int MON_N = 8;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [COND_N-1:0] STICKY_RST = 6'h00;
    localparam logic [COND_N-1:0] IRQ_EN_RST = 6'h00;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // edges after reset release before synchronised monitor flags are valid
    localparam logic [1:0] SYNC_SETTLE = 2'h2;

    // reference selection modes
    typedef enum logic [1:0] {
        MODE_MANUAL,
        MODE_SHORT_HOLD,
        MODE_AUTO,
        MODE_AUTO_HOLD
    } sel_mode_e;

    // raw monitor flags from the pll and input monitor logic
    typedef struct packed {
        logic no_valid_ref;
        logic reselecting;
        logic sel_input1;
        logic vco_cal_done;
        logic in_holdover;
        logic spll_locked;
        logic jpll_locked;
        logic input1_active;
    } mon_s;

    // apb request group
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

endpackage : status_irq_pkg

//--- hw/status_latch_interrupt.sv
// status, sticky latch and interrupt logic with apb register access
//
// Summary of operation
// - live status bits read the current condition at read time
// - sticky bits set on their fault and clear only by writing one
// - a clear has no effect while the fault persists; bit sets again
// - each sticky bit has its own enable; zero masks it from the pin
// - interrupt pin releases only after every enabled sticky bit clears
// - input live bits read 1 when active, 0 on loss of signal
// - jitter pll lock live reads 1 locked, 0 loss of lock
// - synth pll lock live reads 1 locked, 0 loss of lock
// - vco calibration pending reads 1 until calibration completes
// - selected input reads 0 for input 0, 1 for input 1
// - manual and short holdover: reference valid follows selected input
// - automatic: reference valid low while lost and during reselection
// - automatic with holdover: reference valid low while lost in holdover
// - first lock pin follows latched jitter pll lock state
// - second lock pin follows latched synth pll lock state
// - pll loss of lock reaches interrupt only with its enable set
// - holdover live reads 0 in holdover, 1 otherwise
// - reference sticky clear ignored while no valid reference exists
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module status_latch_interrupt
    import status_irq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic input0_active,
    input wire logic input1_active,
    input wire logic jpll_locked,
    input wire logic spll_locked,
    input wire logic in_holdover,
    input wire logic vco_cal_done,
    input wire logic sel_input1,
    input wire logic reselecting,
    input wire logic no_valid_ref,
    output logic irq_n_pin,
    output logic lock_jitter_pin,
    output logic lock_synth_pin
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [COND_N-1:0] sticky;
        logic [COND_N-1:0] irq_en;
        sel_mode_e mode;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic irq_n;
        logic lock_j;
        logic lock_s;
        logic [1:0] warm;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    apb_req_s req;
    mon_s mon_raw;
    mon_s mon;
    logic input0_sync;
    logic [LIVE_N-1:0] live;
    logic [COND_N-1:0] fault;
    logic [COND_N-1:0] clr;
    logic ref_valid;
    logic setup;
    logic wr_hit;
    logic mapped;

    assign req = '{psel, penable, pwrite, paddr, pwdata};

    // ----------------------------------------
    // monitor input synchronisation
    // ----------------------------------------
    assign mon_raw = '{no_valid_ref, reselecting, sel_input1, vco_cal_done,
                       in_holdover, spll_locked, jpll_locked, input1_active};

    sync_two_ff #(
        .W(MON_N + 1)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({mon_raw, input0_active}),
        .sync_out({mon, input0_sync})
    );

    // ----------------------------------------
    // reference valid by selection mode
    // ----------------------------------------
    // selected input activity decides validity
    always_comb begin
        logic sel_active;
        sel_active = mon.sel_input1 ? mon.input1_active : input0_sync;
        unique case (st_r.mode)
            MODE_MANUAL, MODE_SHORT_HOLD: begin
                ref_valid = sel_active;
            end
            MODE_AUTO: begin
                ref_valid = sel_active & ~mon.reselecting;
            end
            MODE_AUTO_HOLD: begin
                ref_valid = sel_active & ~mon.in_holdover;
            end
        endcase
    end

    // ----------------------------------------
    // live status vector
    // ----------------------------------------
    // live bits track the synchronised conditions each cycle
    always_comb begin
        live = '0;
        live[INPUT0_BIT] = input0_sync;
        live[INPUT1_BIT] = mon.input1_active;
        live[JPLL_BIT] = mon.jpll_locked;
        live[SPLL_BIT] = mon.spll_locked;
        live[HOLD_BIT] = ~mon.in_holdover;
        live[REF_BIT] = ref_valid;
        live[VCO_BIT] = ~mon.vco_cal_done;
        live[SEL_BIT] = mon.sel_input1;
    end

    // fault is the inverse of each good condition; held off while the
    // synchronisers still show their reset zeros, so no false latch
    assign fault = (st_r.warm == SYNC_SETTLE) ? ~live[COND_N-1:0] : {COND_N{1'b0}};

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    assign setup = req.psel & ~req.penable;
    assign wr_hit = req.psel & req.penable & st_r.ready & req.pwrite;
    assign mapped = (req.paddr == LIVE_OFS) || (req.paddr == STICKY_OFS) ||
                    (req.paddr == IRQ_EN_OFS) || (req.paddr == MODE_OFS);

    // write-one-clear mask; reference clear blocked with no valid ref
    always_comb begin
        clr = '0;
        if (wr_hit && req.paddr == STICKY_OFS) begin
            clr = req.pwdata[COND_N-1:0];
            if (mon.no_valid_ref) begin
                clr[REF_BIT] = 1'b0;
            end
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.ready = setup;
        st_nxt.slverr = setup & ~mapped;
        // count the settling edges after reset, then stay
        st_nxt.warm = (st_r.warm == SYNC_SETTLE) ? st_r.warm : st_r.warm + 2'h1;
        // read data captured in setup, shown in access phase
        if (setup && !req.pwrite) begin
            unique case (req.paddr)
                LIVE_OFS: st_nxt.rdata = {24'h00_0000, live};
                STICKY_OFS: st_nxt.rdata = {26'h0, st_r.sticky};
                IRQ_EN_OFS: st_nxt.rdata = {26'h0, st_r.irq_en};
                MODE_OFS: st_nxt.rdata = {30'h0, st_r.mode};
                default: st_nxt.rdata = RDATA_RST;
            endcase
        end
        // set wins over clear, so a persisting fault re-latches
        st_nxt.sticky = (st_r.sticky & ~clr) | fault;
        if (wr_hit && req.paddr == IRQ_EN_OFS) begin
            st_nxt.irq_en = req.pwdata[COND_N-1:0];
        end
        if (wr_hit && req.paddr == MODE_OFS) begin
            st_nxt.mode = sel_mode_e'(req.pwdata[1:0]);
        end
        // pin asserted by any enabled sticky bit
        st_nxt.irq_n = ~|(st_nxt.sticky & st_nxt.irq_en);
        st_nxt.lock_j = ~st_nxt.sticky[JPLL_BIT];
        st_nxt.lock_s = ~st_nxt.sticky[SPLL_BIT];
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // reset leaves all latches and enables clear, pin released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.sticky <= STICKY_RST;
            st_r.irq_en <= IRQ_EN_RST;
            st_r.mode <= MODE_MANUAL;
            st_r.rdata <= RDATA_RST;
            st_r.ready <= 1'b0;
            st_r.slverr <= 1'b0;
            st_r.irq_n <= 1'b1;
            st_r.lock_j <= 1'b1;
            st_r.lock_s <= 1'b1;
            st_r.warm <= 2'h0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign prdata = st_r.rdata;
    assign pready = st_r.ready;
    assign pslverr = st_r.slverr;
    assign irq_n_pin = st_r.irq_n;
    assign lock_jitter_pin = st_r.lock_j;
    assign lock_synth_pin = st_r.lock_s;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence clear_write_s(int b);
        psel && penable && pready && pwrite && paddr == STICKY_OFS && pwdata[b];
    endsequence

    // a latched bit with no clear stays set
    sticky_hold_a: assert property (
        st_r.sticky[JPLL_BIT] && !clr[JPLL_BIT] |=> st_r.sticky[JPLL_BIT]
    ) else $error("sticky bit dropped without clear");

    // persisting fault re-latches through a clear
    clear_persist_a: assert property (
        clear_write_s(INPUT1_BIT) ##0 fault[INPUT1_BIT] |=> st_r.sticky[INPUT1_BIT]
    ) else $error("sticky bit cleared while fault present");

    // clean clear drops the bit
    clear_clean_a: assert property (
        clear_write_s(SPLL_BIT) ##0 !fault[SPLL_BIT] |=> !st_r.sticky[SPLL_BIT]
    ) else $error("write one did not clear sticky bit");

    // masked bits never drive the pin
    mask_gate_a: assert property (
        (st_r.irq_en == '0) |-> irq_n_pin
    ) else $error("interrupt with all enables zero");

    // pin tracks enabled sticky set
    pin_track_a: assert property (
        irq_n_pin == ~|(st_r.sticky & st_r.irq_en)
    ) else $error("interrupt pin disagrees with sticky and enable");

    // jitter pll loss reaches pin when enabled
    pll_enable_a: assert property (
        st_r.sticky[JPLL_BIT] && st_r.irq_en[JPLL_BIT] |-> !irq_n_pin
    ) else $error("enabled pll loss did not assert pin");

    // pin stays released until a new enabled latch
    release_hold_a: assert property (
        irq_n_pin && ~|(st_nxt.sticky & st_nxt.irq_en) |=> irq_n_pin
    ) else $error("pin asserted without enabled latch");

    // lock pins follow the latched pll state
    lock_pins_a: assert property (
        lock_jitter_pin == !st_r.sticky[JPLL_BIT] &&
        lock_synth_pin == !st_r.sticky[SPLL_BIT]
    ) else $error("lock pin disagrees with latched pll state");

    // reference clear blocked with no valid reference
    ref_block_a: assert property (
        clear_write_s(REF_BIT) ##0 mon.no_valid_ref && st_r.sticky[REF_BIT]
        |=> st_r.sticky[REF_BIT]
    ) else $error("reference sticky cleared with no valid reference");

    // live read returns the sampled live flags
    live_read_a: assert property (
        psel && !penable && !pwrite && paddr == LIVE_OFS
        |=> pready && prdata[LIVE_N-1:0] == $past(live)
    ) else $error("live read data mismatch");

    // automatic mode drops reference valid during reselection
    auto_resel_a: assert property (
        st_r.mode == MODE_AUTO && mon.reselecting |-> !live[REF_BIT]
    ) else $error("reference valid high during reselection");

    // holdover live inverse of holdover state
    hold_live_a: assert property (
        live[HOLD_BIT] == !mon.in_holdover
    ) else $error("holdover live bit wrong");

    // no latching while the synchronisers settle after reset
    warm_gate_a: assert property (
        st_r.warm != SYNC_SETTLE && st_r.sticky == '0 |=> st_r.sticky == '0
    ) else $error("sticky bit set before synchronisers settled");

    // a present fault latches at the next edge
    hold_set_a: assert property (
        fault[HOLD_BIT] |=> st_r.sticky[HOLD_BIT]
    ) else $error("holdover fault did not latch");

    // input live bits follow the synchronised activity
    input_live_a: assert property (
        live[INPUT0_BIT] == input0_sync && live[INPUT1_BIT] == mon.input1_active
    ) else $error("input live bit wrong");

    // pll live bits follow the synchronised lock state
    pll_live_a: assert property (
        live[JPLL_BIT] == mon.jpll_locked && live[SPLL_BIT] == mon.spll_locked
    ) else $error("pll live bit wrong");

    // calibration pending and selection bits
    vco_sel_a: assert property (
        live[VCO_BIT] == !mon.vco_cal_done && live[SEL_BIT] == mon.sel_input1
    ) else $error("calibration or selection live bit wrong");

    // manual modes report the selected input directly
    manual_ref_a: assert property (
        (st_r.mode == MODE_MANUAL || st_r.mode == MODE_SHORT_HOLD)
        |-> live[REF_BIT] == (mon.sel_input1 ? mon.input1_active : input0_sync)
    ) else $error("reference valid wrong in manual mode");

    // automatic with holdover drops reference valid in holdover
    hold_ref_a: assert property (
        st_r.mode == MODE_AUTO_HOLD && mon.in_holdover |-> !live[REF_BIT]
    ) else $error("reference valid high in holdover");

    // enable write lands at the access edge
    enable_write_a: assert property (
        psel && penable && pready && pwrite && paddr == IRQ_EN_OFS
        |=> st_r.irq_en == $past(pwdata[COND_N-1:0])
    ) else $error("interrupt enable write lost");

    // synth pll loss reaches pin when enabled
    synth_enable_a: assert property (
        st_r.sticky[SPLL_BIT] && st_r.irq_en[SPLL_BIT] |-> !irq_n_pin
    ) else $error("enabled synth pll loss did not assert pin");

    // ready stands one cycle only
    ready_pulse_a: assert property (
        pready |=> !pready
    ) else $error("ready held longer than one cycle");

    // error response only together with ready
    slverr_ready_a: assert property (
        pslverr |-> pready
    ) else $error("error response without ready");

endmodule : status_latch_interrupt
`default_nettype wire

//--- hw/sync_two_ff.sv
// two flip-flop synchroniser, one chain per bit
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff
    import status_irq_pkg::*;
#(
    parameter int W = 9
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_s;

    sync_s st_r;
    sync_s st_nxt;

    // ----------------------------------------
    // per-bit chains
    // ----------------------------------------
    // first stage feeds only the second stage
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_comb begin
            st_nxt.meta[i] = async_in[i];
            st_nxt.stable[i] = st_r.meta[i];
        end
    end

    // register the chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stable;

endmodule : sync_two_ff
`default_nettype wire

//--- tb/monitor_model.sv
// monitor flag source model for the status block
`timescale 1ns/1ps
`default_nettype none
module monitor_model
    import status_irq_pkg::*;
(
    input wire logic pclk,
    input wire mon_s want,
    input wire logic want_in0,
    output var mon_s flags,
    output var logic in0_flag
);
    // flags move on the falling edge, unrelated to the sampling edge
    always @(negedge pclk) begin
        flags <= want;
        in0_flag <= want_in0;
    end
endmodule : monitor_model
`default_nettype wire

//--- tb/tb_status_latch_interrupt.sv
// testbench for the status, sticky latch and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_status_latch_interrupt
    import status_irq_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, in0, in0_flag, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, rd, exp_s;
    logic [31:0] prdata;
    logic pready, pslverr, irq_n_pin, lock_jitter_pin, lock_synth_pin;
    logic [1:0] mode;
    mon_s mon, flags;
    integer errors, tests_run;

    monitor_model partner (.pclk(pclk), .want(mon), .want_in0(in0), .flags(flags), .in0_flag(in0_flag));

    status_latch_interrupt DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .input0_active(in0_flag), .input1_active(flags.input1_active),
        .jpll_locked(flags.jpll_locked), .spll_locked(flags.spll_locked),
        .in_holdover(flags.in_holdover), .vco_cal_done(flags.vco_cal_done),
        .sel_input1(flags.sel_input1), .reselecting(flags.reselecting),
        .no_valid_ref(flags.no_valid_ref), .irq_n_pin(irq_n_pin),
        .lock_jitter_pin(lock_jitter_pin), .lock_synth_pin(lock_synth_pin));

    // clock at 10 MHz
    always #50 pclk = ~pclk;

    // ----------------------------------------
    // bus tasks and compares
    // ----------------------------------------
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // wait for the rising edge at which pready is seen high
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk_pin(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_pin

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d, rd, er);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0, rd, er);
        chk32(rd, exp);
    endtask : rd_chk

    // live word worked out from the flags the model presents
    function automatic logic [31:0] live_exp();
        logic sa;
        logic rv;
        sa = mon.sel_input1 ? mon.input1_active : in0;
        case (mode)
            2'h2: rv = sa & !mon.reselecting;
            2'h3: rv = sa & !mon.in_holdover;
            default: rv = sa;
        endcase
        return {24'h0, mon.sel_input1, !mon.vco_cal_done, rv, !mon.in_holdover,
                mon.spll_locked, mon.jpll_locked, mon.input1_active, in0};
    endfunction : live_exp

    task automatic restore();
        mon = 8'h17;
        in0 = 1'h1;
        repeat (6) @(posedge pclk);
    endtask : restore

    // fault, refused clear, recovery and clear
    task automatic fault_cycle();
        exp_s = ~live_exp() & 32'h3F;
        repeat (6) @(posedge pclk);
        rd_chk(LIVE_OFS, live_exp());
        rd_chk(STICKY_OFS, exp_s);
        chk_pin(irq_n_pin, exp_s == 32'h0);
        chk_pin(lock_jitter_pin, !exp_s[2]);
        chk_pin(lock_synth_pin, !exp_s[3]);
        wr(STICKY_OFS, 32'h3F);
        rd_chk(STICKY_OFS, exp_s);
        restore();
        rd_chk(STICKY_OFS, exp_s);
        chk_pin(lock_jitter_pin, !exp_s[2]);
        wr(STICKY_OFS, 32'h3F);
        repeat (3) @(posedge pclk);
        rd_chk(STICKY_OFS, 32'h0);
        chk_pin(irq_n_pin, 1'h1);
    endtask : fault_cycle

    task automatic wrap_up();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        pclk = 1'h0;
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        errors = 0;
        tests_run = 0;
        mode = 2'h0;
        mon = 8'h17;
        in0 = 1'h1;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        repeat (6) @(posedge pclk);
        chk_pin(irq_n_pin, 1'h1);
        rd_chk(STICKY_OFS, 32'h0);
        rd_chk(IRQ_EN_OFS, 32'h0);
        rd_chk(LIVE_OFS, live_exp());
        // unmapped place and read-only live word
        apb(1'h0, 8'h10, 32'h0, rd, er);
        chk32(rd, 32'h0);
        chk_pin(er, 1'h1);
        wr(LIVE_OFS, 32'hFF);
        rd_chk(LIVE_OFS, live_exp());
        // masked loss of lock, then unmasked
        wr(IRQ_EN_OFS, 32'h8);
        mon.jpll_locked = 1'h0;
        repeat (6) @(posedge pclk);
        chk_pin(irq_n_pin, 1'h1);
        chk_pin(lock_jitter_pin, 1'h0);
        chk_pin(lock_synth_pin, 1'h1);
        wr(IRQ_EN_OFS, 32'h4);
        repeat (3) @(posedge pclk);
        chk_pin(irq_n_pin, 1'h0);
        restore();
        wr(STICKY_OFS, 32'h4);
        repeat (3) @(posedge pclk);
        chk_pin(irq_n_pin, 1'h1);
        chk_pin(lock_jitter_pin, 1'h1);
        wr(IRQ_EN_OFS, 32'h3F);
        rd_chk(IRQ_EN_OFS, 32'h3F);
        // every condition and selection mode in turn
        for (int k = 0; k < 8; k++) begin
            mode = 2'h0;
            case (k)
                0: in0 = 1'h0;
                1: mon.input1_active = 1'h0;
                2: mon.jpll_locked = 1'h0;
                3: mon.spll_locked = 1'h0;
                4: mon.in_holdover = 1'h1;
                5: begin
                    mode = 2'h2;
                    mon.reselecting = 1'h1;
                end
                6: begin
                    mode = 2'h3;
                    mon.in_holdover = 1'h1;
                end
                default: begin
                    mode = 2'h1;
                    mon.sel_input1 = 1'h1;
                    mon.vco_cal_done = 1'h0;
                end
            endcase
            wr(MODE_OFS, {30'h0, mode});
            fault_cycle();
        end
        // reference clear refused without a valid reference
        wr(MODE_OFS, 32'h3);
        mon.in_holdover = 1'h1;
        mon.no_valid_ref = 1'h1;
        repeat (6) @(posedge pclk);
        mon.in_holdover = 1'h0;
        repeat (6) @(posedge pclk);
        wr(STICKY_OFS, 32'h30);
        rd_chk(STICKY_OFS, 32'h20);
        chk_pin(irq_n_pin, 1'h0);
        restore();
        wr(STICKY_OFS, 32'h20);
        rd_chk(STICKY_OFS, 32'h0);
        wrap_up();
    end

    // watchdog against a hang
    initial begin
        repeat (8000) @(posedge pclk);
        errors++;
        wrap_up();
    end
endmodule : tb_status_latch_interrupt
`default_nettype wire
